// ==== core/salh_hash.sv ====
`timescale 1ns/10ps
module salh_hash (
   salh_hash_if.hasher hif // address in, bucket index out
);
   logic [salh_pkg::HASH_W-1:0] hv;

   // msb of the address enters first
   function automatic logic [salh_pkg::HASH_W-1:0] crc16(
      input logic [salh_pkg::MAC_W-1:0] d);
      logic [salh_pkg::HASH_W-1:0] c;
      logic fb;
      c = salh_pkg::CRC_INIT;
      for (int i = salh_pkg::MAC_W - 1; i >= 0; i--) begin
         fb = c[salh_pkg::HASH_W-1] ^ d[i];
         c = {c[salh_pkg::HASH_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ salh_pkg::CRC_POLY;
         end
      end
      return c;
   endfunction

   always_comb begin
      case (hif.mode)
         salh_pkg::HASH_CRC: hv = crc16(hif.mac);
         salh_pkg::HASH_XOR: hv = hif.mac[47:32] ^ hif.mac[31:16] ^ hif.mac[15:0];
         default: hv = {6'h00, hif.mac[salh_pkg::IDX_W-1:0]};
      endcase
   end

   // carry out of bit 9 is dropped so the index wraps inside the table
   assign hif.index = hv[salh_pkg::IDX_W-1:0] + {3'h0, hif.fgrp};
endmodule // salh_hash

// ==== core/salh_hash_if.sv ====
`timescale 1ns/10ps
interface salh_hash_if;
   logic [salh_pkg::MAC_W-1:0] mac;
   logic [salh_pkg::FGRP_W-1:0] fgrp;
   salh_pkg::salh_hash_mode_t mode;
   logic [salh_pkg::IDX_W-1:0] index;
   modport client (output mac, output fgrp, output mode, input index);
   modport hasher (input mac, input fgrp, input mode, output index);
endinterface

// ==== core/salh_lookup.sv ====
`timescale 1ns/10ps
// What this block does
// - lookup spans 4K main table, 16 static entries, 8 reserved multicast entries.
// - main table is 1K buckets of four ways.
// - address, optionally with filter group, hashes to a 10-bit bucket index.
// - all four ways of the bucket compare address and filter group at once.
// - vlan enabled puts the frame filter group into the hash.
// - vlan disabled hashes with filter group zero.
// - default mode adds low ten CRC bits to zero-extended filter group.
// - CRC uses the CCITT polynomial x16+x12+x5+1.
// - xor mode adds low ten bits of folded address to filter group.
// - direct modes add ten low address bits to filter group.
// - hardware learns dynamic entries; only software writes static entries.
// - good frame with known destination returns that destination's ports.
// - host port is the one tail-tagged port; only one allowed. Several tagged ports raise host_conflict and the lowest one is used.
// - store-and-forward; lookup only after whole frame, good or bad, 256KB shared buffer.
// - static matches beat dynamic matches.
// - learn only unicast, unknown source from error-free legal-length frame.
// - full bucket evicts oldest dynamic, never static; all static raises event.
module salh_lookup (
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset
   input wire logic vlan_en, // include frame filter group
   input wire logic [1:0] hash_mode, // hash option select
   input wire logic rsv_en, // reserved multicast table on
   input wire logic [salh_pkg::PORTS-1:0] tail_tag_en, // tail tagging per port
   input wire logic req_valid, // lookup request
   output logic req_ready, // idle, request taken
   input wire logic [salh_pkg::MAC_W-1:0] req_da, // destination address
   input wire logic [salh_pkg::MAC_W-1:0] req_sa, // source address
   input wire logic [salh_pkg::FGRP_W-1:0] req_fgrp, // frame filter group
   input wire logic [salh_pkg::PORT_W-1:0] req_port, // ingress port
   input wire logic req_frame_ok, // no errors, legal length
   output logic res_valid, // result pulse
   output logic res_hit, // destination known
   output logic [salh_pkg::PORTS-1:0] res_ports, // forwarding ports
   output logic learn_full, // all four ways static pulse
   output logic [salh_pkg::IDX_W-1:0] learn_full_bucket, // bucket of that event
   output logic [salh_pkg::PORT_W-1:0] host_port, // tail-tagged port
   output logic host_valid, // a host port exists
   output logic host_conflict, // more than one tagged port
   input wire logic mgmt_wr, // software entry write
   input wire logic mgmt_sel, // 0 main table, 1 static table
   input wire logic [salh_pkg::ENT_W-1:0] mgmt_idx, // bucket and way, or static slot
   input wire logic mgmt_valid, // entry valid, 0 deletes
   input wire logic [salh_pkg::MAC_W-1:0] mgmt_mac, // entry address
   input wire logic [salh_pkg::FGRP_W-1:0] mgmt_fgrp, // entry filter group
   input wire logic [salh_pkg::PORTS-1:0] mgmt_ports, // entry ports
   input wire logic rsv_wr, // reserved table port write
   input wire logic [salh_pkg::RSV_W-1:0] rsv_idx, // reserved group
   input wire logic [salh_pkg::PORTS-1:0] rsv_ports // reserved group ports
);
   localparam int W = salh_pkg::WAYS;

   salh_pkg::salh_state_t state_q;
   logic [salh_pkg::MAC_W-1:0] da_q, sa_q;
   logic [salh_pkg::FGRP_W-1:0] fgrp_q;
   logic [salh_pkg::PORT_W-1:0] port_q;
   logic ok_q;
   logic [salh_pkg::IDX_W-1:0] bkt;
   // ****************************************
   // tables
   // ****************************************
   logic v_q [salh_pkg::ENTRIES];
   logic stc_q [salh_pkg::ENTRIES];
   logic [salh_pkg::AGE_W-1:0] age_q [salh_pkg::ENTRIES];
   logic [salh_pkg::MAC_W-1:0] mac_q [salh_pkg::ENTRIES];
   logic [salh_pkg::FGRP_W-1:0] efgrp_q [salh_pkg::ENTRIES];
   logic [salh_pkg::PORTS-1:0] eport_q [salh_pkg::ENTRIES];
   logic sv_q [salh_pkg::STATIC_N];
   logic [salh_pkg::MAC_W-1:0] smac_q [salh_pkg::STATIC_N];
   logic [salh_pkg::FGRP_W-1:0] sfgrp_q [salh_pkg::STATIC_N];
   logic [salh_pkg::PORTS-1:0] sport_q [salh_pkg::STATIC_N];
   logic [salh_pkg::PORTS-1:0] rport_q [salh_pkg::RSV_N];

   logic [W-1:0] way_hit, way_v, way_st;
   logic [salh_pkg::AGE_W-1:0] way_age [W];
   logic st_hit, rsv_hit, mst_hit, mdy_hit, lrn_ok, vic_ok, lrn_we, full_evt, tbl_we;
   logic [salh_pkg::PORTS-1:0] st_ports, mst_ports, mdy_ports;
   logic [salh_pkg::WAY_W-1:0] victim;
   logic [salh_pkg::ENT_W-1:0] widx;
   logic [3:0] rsv_g;

   salh_hash_if hif ();
   salh_hash u_hash (.hif(hif));

   assign req_ready = (state_q == salh_pkg::S_IDLE);
   assign hif.mac = (state_q == salh_pkg::S_SA) ? sa_q : da_q;
   assign hif.fgrp = fgrp_q;
   assign hif.mode = salh_pkg::salh_hash_mode_t'(hash_mode);
   assign bkt = hif.index;

   // {hit, group} for the reserved multicast range
   function automatic logic [3:0] rsv_group(input logic [salh_pkg::MAC_W-1:0] m);
      logic [7:0] b;
      b = m[7:0];
      rsv_group = 4'h0;
      if (m[47:8] == salh_pkg::RSV_PREFIX) begin
         if (b == 8'h00) rsv_group = 4'h8;
         else if (b == 8'h01) rsv_group = 4'h9;
         else if (b == 8'h03) rsv_group = 4'hA;
         else if (b == 8'h10) rsv_group = 4'hB;
         else if (b == 8'h20) rsv_group = 4'hC;
         else if (b == 8'h21) rsv_group = 4'hD;
         else if (b == 8'h02 || (b >= 8'h04 && b <= 8'h0F)) rsv_group = 4'hE;
         else if ((b >= 8'h11 && b <= 8'h1F) || (b >= 8'h22 && b <= 8'h2F)) rsv_group = 4'hF;
      end
   endfunction

   function automatic int ones(input logic [salh_pkg::PORTS-1:0] v);
      ones = 0;
      for (int i = 0; i < salh_pkg::PORTS; i++) ones += int'(v[i]);
   endfunction

   // ****************************************
   // sequencing
   // ****************************************
   // a request is only offered once the whole frame sits in the shared buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= salh_pkg::S_IDLE;
      end else begin
         case (state_q)
            salh_pkg::S_IDLE: if (req_valid) state_q <= salh_pkg::S_DA;
            salh_pkg::S_DA: state_q <= salh_pkg::S_SA;
            salh_pkg::S_SA: state_q <= salh_pkg::S_IDLE;
            default: state_q <= salh_pkg::S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         da_q <= '0;
         sa_q <= '0;
         fgrp_q <= '0;
         port_q <= '0;
         ok_q <= 1'b0;
      end else if (req_valid && req_ready) begin
         da_q <= req_da;
         sa_q <= req_sa;
         fgrp_q <= vlan_en ? req_fgrp : salh_pkg::DEFAULT_FGRP;
         port_q <= req_port;
         ok_q <= req_frame_ok;
      end
   end

   // ****************************************
   // compare and select
   // ****************************************
   always_comb begin
      logic [salh_pkg::ENT_W-1:0] e;
      logic [salh_pkg::AGE_W-1:0] best;
      e = '0;
      best = '0;
      mst_hit = 1'b0;
      mdy_hit = 1'b0;
      mst_ports = '0;
      mdy_ports = '0;
      for (int w = 0; w < W; w++) begin
         e = {bkt, salh_pkg::WAY_W'(w)};
         way_v[w] = v_q[e];
         way_st[w] = stc_q[e];
         way_age[w] = age_q[e];
         way_hit[w] = v_q[e] && mac_q[e] == hif.mac && efgrp_q[e] == fgrp_q;
         if (way_hit[w] && stc_q[e]) begin
            mst_hit = 1'b1;
            mst_ports = eport_q[e];
         end
         if (way_hit[w] && !stc_q[e]) begin
            mdy_hit = 1'b1;
            mdy_ports = eport_q[e];
         end
      end
      st_hit = 1'b0;
      st_ports = '0;
      for (int s = salh_pkg::STATIC_N - 1; s >= 0; s--) begin
         if (sv_q[s] && smac_q[s] == da_q && sfgrp_q[s] == fgrp_q) begin
            st_hit = 1'b1;
            st_ports = sport_q[s];
         end
      end
      rsv_g = rsv_group(da_q);
      rsv_hit = rsv_en && rsv_g[3];
      // first empty way, else the oldest dynamic way; statics never chosen
      vic_ok = 1'b0;
      victim = '0;
      for (int w = W - 1; w >= 0; w--) begin
         if (!way_v[w]) begin
            vic_ok = 1'b1;
            victim = salh_pkg::WAY_W'(w);
         end
      end
      if (!vic_ok) begin
         for (int w = 0; w < W; w++) begin
            if (!way_st[w] && (!vic_ok || way_age[w] > best)) begin
               vic_ok = 1'b1;
               victim = salh_pkg::WAY_W'(w);
               best = way_age[w];
            end
         end
      end
   end

   assign lrn_ok = ok_q && !sa_q[salh_pkg::MCAST_BIT] && !(|way_hit);
   assign lrn_we = state_q == salh_pkg::S_SA && lrn_ok && vic_ok && !(mgmt_wr && !mgmt_sel);
   assign full_evt = state_q == salh_pkg::S_SA && lrn_ok && !vic_ok;
   assign tbl_we = (mgmt_wr && !mgmt_sel) || lrn_we;
   assign widx = (mgmt_wr && !mgmt_sel) ? mgmt_idx : {bkt, victim};

   // ****************************************
   // table updates
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < salh_pkg::ENTRIES; i++) begin
            v_q[i] <= 1'b0;
            stc_q[i] <= 1'b0;
         end
      end else if (tbl_we) begin
         v_q[widx] <= lrn_we ? 1'b1 : mgmt_valid;
         stc_q[widx] <= !lrn_we;
      end
   end

   always_ff @(posedge clk) begin
      if (tbl_we) begin
         mac_q[widx] <= lrn_we ? sa_q : mgmt_mac;
         efgrp_q[widx] <= lrn_we ? fgrp_q : mgmt_fgrp;
         eport_q[widx] <= lrn_we ? salh_pkg::PORTS'(1 << port_q) : mgmt_ports;
      end
   end

   // ages only order the ways of a bucket for eviction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < salh_pkg::ENTRIES; i++) age_q[i] <= '0;
      end else if (mgmt_wr && !mgmt_sel) begin
         age_q[mgmt_idx] <= '0;
      end else if (state_q == salh_pkg::S_SA) begin
         for (int w = 0; w < W; w++) begin
            if (way_hit[w] || (lrn_we && victim == salh_pkg::WAY_W'(w))) begin
               age_q[{bkt, salh_pkg::WAY_W'(w)}] <= '0;
            end else if (lrn_we && way_v[w] && way_age[w] != salh_pkg::AGE_MAX) begin
               age_q[{bkt, salh_pkg::WAY_W'(w)}] <= way_age[w] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < salh_pkg::STATIC_N; s++) sv_q[s] <= 1'b0;
      end else if (mgmt_wr && mgmt_sel) begin
         sv_q[mgmt_idx[salh_pkg::ST_W-1:0]] <= mgmt_valid;
      end
   end

   always_ff @(posedge clk) begin
      if (mgmt_wr && mgmt_sel) begin
         smac_q[mgmt_idx[salh_pkg::ST_W-1:0]] <= mgmt_mac;
         sfgrp_q[mgmt_idx[salh_pkg::ST_W-1:0]] <= mgmt_fgrp;
         sport_q[mgmt_idx[salh_pkg::ST_W-1:0]] <= mgmt_ports;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int r = 0; r < salh_pkg::RSV_N; r++) rport_q[r] <= salh_pkg::RSV_DEFAULT[r];
      end else if (rsv_wr) begin
         rport_q[rsv_idx] <= rsv_ports;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_valid <= 1'b0;
         res_hit <= 1'b0;
         res_ports <= '0;
      end else begin
         res_valid <= state_q == salh_pkg::S_DA;
         if (state_q == salh_pkg::S_DA) begin
            res_hit <= st_hit || rsv_hit || mst_hit || mdy_hit;
            if (st_hit) res_ports <= st_ports;
            else if (rsv_hit) res_ports <= rport_q[rsv_g[salh_pkg::RSV_W-1:0]];
            else if (mst_hit) res_ports <= mst_ports;
            else res_ports <= mdy_ports;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         learn_full <= 1'b0;
         learn_full_bucket <= '0;
      end else begin
         learn_full <= full_evt;
         if (full_evt) learn_full_bucket <= bkt;
      end
   end

   // lowest tagged port wins when software tags several
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_port <= '0;
         host_valid <= 1'b0;
         host_conflict <= 1'b0;
      end else begin
         host_valid <= |tail_tag_en;
         host_conflict <= ones(tail_tag_en) > 1;
         for (int p = salh_pkg::PORTS - 1; p >= 0; p--) begin
            if (tail_tag_en[p]) host_port <= salh_pkg::PORT_W'(p);
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_res_timing;
      @(posedge clk) disable iff (!rst_n) req_valid && req_ready |-> ##2 res_valid;
   endproperty
   a_res_timing: assert property (p_res_timing) else $error("result not two cycles after request");
   property p_busy;
      @(posedge clk) disable iff (!rst_n) req_valid && req_ready |=> !req_ready [*2] ##1 req_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("lookup occupancy wrong");
   property p_group_off;
      @(posedge clk) disable iff (!rst_n)
         req_valid && req_ready && !vlan_en |=> fgrp_q == salh_pkg::DEFAULT_FGRP;
   endproperty
   a_group_off: assert property (p_group_off) else $error("filter group not zero with vlan off");
   property p_learn_unicast;
      @(posedge clk) disable iff (!rst_n) lrn_we |-> ok_q && !sa_q[salh_pkg::MCAST_BIT];
   endproperty
   a_learn_unicast: assert property (p_learn_unicast) else $error("bad source learned");
   property p_no_static_evict;
      @(posedge clk) disable iff (!rst_n) lrn_we |-> !(way_v[victim] && way_st[victim]);
   endproperty
   a_no_static_evict: assert property (p_no_static_evict) else $error("static way evicted");
   property p_full_evt;
      @(posedge clk) disable iff (!rst_n)
         full_evt |-> &way_st && &way_v ##1 learn_full && learn_full_bucket == $past(bkt);
   endproperty
   a_full_evt: assert property (p_full_evt) else $error("full bucket event wrong");
   property p_static_prio;
      @(posedge clk) disable iff (!rst_n)
         state_q == salh_pkg::S_DA && st_hit |=> res_hit && res_ports == $past(st_ports);
   endproperty
   a_static_prio: assert property (p_static_prio) else $error("static entry lost priority");
   property p_host_one;
      @(posedge clk) disable iff (!rst_n) ones(tail_tag_en) > 1 |=> host_conflict;
   endproperty
   a_host_one: assert property (p_host_one) else $error("two tagged ports not flagged");
endmodule // salh_lookup

// ==== core/salh_pkg.sv ====
package salh_pkg;
   // ****************************************
   // table geometry
   // ****************************************
   localparam int MAC_W = 48;
   localparam int FGRP_W = 7;
   localparam int IDX_W = 10;
   localparam int WAYS = 4;
   localparam int WAY_W = 2;
   localparam int BUCKETS = 1024;
   localparam int ENTRIES = BUCKETS * WAYS;
   localparam int ENT_W = IDX_W + WAY_W;
   localparam int STATIC_N = 16;
   localparam int ST_W = 4;
   localparam int RSV_N = 8;
   localparam int RSV_W = 3;
   localparam int PORTS = 7;
   localparam int PORT_W = 3;
   localparam int AGE_W = 2;
   localparam int HASH_W = 16;
   localparam int BUFFER_BYTES = 262144;
   // ****************************************
   // hashing and address fields
   // ****************************************
   localparam logic [HASH_W-1:0] CRC_POLY = 16'h1021;
   localparam logic [HASH_W-1:0] CRC_INIT = 16'hFFFF;
   localparam logic [FGRP_W-1:0] DEFAULT_FGRP = 7'h00;
   localparam int MCAST_BIT = 40;
   localparam logic [39:0] RSV_PREFIX = 40'h0180C20000;
   localparam logic [PORTS-1:0] RSV_DEFAULT [RSV_N] = '{7'h40, 7'h00, 7'h40, 7'h7F,
                                                        7'h3F, 7'h3F, 7'h40, 7'h3F};
   localparam logic [AGE_W-1:0] AGE_MAX = 2'h3;
   typedef enum logic [1:0] {
      HASH_DIRECT0 = 2'b00,
      HASH_CRC = 2'b01,
      HASH_XOR = 2'b10,
      HASH_DIRECT1 = 2'b11
   } salh_hash_mode_t;
   typedef enum logic [1:0] {S_IDLE, S_DA, S_SA} salh_state_t;
endpackage

// ==== tb/salh_lookup_tb_top.sv ====
`timescale 1ns/10ps
module salh_lookup_tb_top;
   // ****************************************
   // wiring
   // ****************************************
   localparam logic [47:0] SA_MC = 48'h0100_0000_0000;
   logic clk, rst_n, vlan_en, rsv_en, req_valid, req_ready, req_frame_ok;
   logic res_valid, res_hit, learn_full, host_valid, host_conflict;
   logic mgmt_wr, mgmt_sel, mgmt_valid, rsv_wr;
   logic [1:0] hash_mode;
   logic [6:0] tail_tag_en, req_fgrp, res_ports, mgmt_fgrp, mgmt_ports, rsv_ports, fgrp, ef;
   logic [47:0] req_da, req_sa, mgmt_mac, mac;
   logic [2:0] req_port, host_port, rsv_idx;
   logic [11:0] mgmt_idx;
   logic [9:0] learn_full_bucket, full_bkt;
   int num_errors = 0;
   int samples_checked = 0;
   int full_seen = 0;
   integer seed = 41;
   logic [7:0] exp_q[$];

   salh_lookup u_salh_lookup (.clk(clk), .rst_n(rst_n), .vlan_en(vlan_en),
      .hash_mode(hash_mode), .rsv_en(rsv_en), .tail_tag_en(tail_tag_en),
      .req_valid(req_valid), .req_ready(req_ready), .req_da(req_da), .req_sa(req_sa),
      .req_fgrp(req_fgrp), .req_port(req_port), .req_frame_ok(req_frame_ok),
      .res_valid(res_valid), .res_hit(res_hit), .res_ports(res_ports),
      .learn_full(learn_full), .learn_full_bucket(learn_full_bucket),
      .host_port(host_port), .host_valid(host_valid), .host_conflict(host_conflict),
      .mgmt_wr(mgmt_wr), .mgmt_sel(mgmt_sel), .mgmt_idx(mgmt_idx),
      .mgmt_valid(mgmt_valid), .mgmt_mac(mgmt_mac), .mgmt_fgrp(mgmt_fgrp),
      .mgmt_ports(mgmt_ports), .rsv_wr(rsv_wr), .rsv_idx(rsv_idx), .rsv_ports(rsv_ports));

   salh_rx_mac_model u_salh_rx_mac_model (.clk(clk), .req_ready(req_ready),
      .req_valid(req_valid), .req_da(req_da), .req_sa(req_sa), .req_fgrp(req_fgrp),
      .req_port(req_port), .req_frame_ok(req_frame_ok));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // checking
   // ****************************************
   task automatic chk(input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checked %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // crc init all ones, address msb first; index wraps in ten bits
   function automatic logic [9:0] bidx(input logic [47:0] m, input logic [6:0] f,
                                       input logic [1:0] md);
      logic [15:0] h;
      logic fb;
      h = 16'hFFFF;
      for (int i = 47; i >= 0; i--) begin
         fb = h[15] ^ m[i];
         h = {h[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
      if (md == 2'b10) h = m[47:32] ^ m[31:16] ^ m[15:0];
      if (md[0] == md[1]) h = m[15:0];
      return h[9:0] + {3'h0, f};
   endfunction

   always @(negedge clk) begin
      if (rst_n && res_valid)
         chk({8'h0, res_hit, res_ports},
             exp_q.size() != 0 ? {8'h0, exp_q.pop_front()} : 16'hFFFF);
      if (rst_n && learn_full) begin
         full_seen++;
         full_bkt = learn_full_bucket;
      end
   end

   task automatic mg(input logic sel, input logic [11:0] idx, input logic [47:0] m,
                     input logic [6:0] f, p);
      @(posedge clk);
      #1;
      mgmt_wr = 1'b1;
      mgmt_sel = sel;
      mgmt_idx = idx;
      mgmt_valid = 1'b1;
      mgmt_mac = m;
      mgmt_fgrp = f;
      mgmt_ports = p;
      @(posedge clk);
      #1;
      mgmt_wr = 1'b0;
   endtask

   // settings stay put for the two busy cycles after the take
   task automatic lk(input logic [47:0] da, sa, input logic [6:0] f, input logic [2:0] p,
                     input logic ok, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_salh_rx_mac_model.send(da, sa, f, p, ok);
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      {vlan_en, rsv_en, mgmt_wr, mgmt_sel, mgmt_valid, rsv_wr} = 6'h00;
      hash_mode = 2'b01;
      tail_tag_en = 7'h00;
      mgmt_idx = 12'h000;
      mgmt_mac = 48'h0;
      {mgmt_fgrp, mgmt_ports, rsv_ports} = 21'h0;
      rsv_idx = 3'h0;
      repeat (4) @(posedge clk);
      #1;
      chk({11'h0, req_ready, res_valid, learn_full, host_valid, host_conflict}, 16'h0010);
      rst_n = 1'b1;
      tail_tag_en = 7'h40;
      repeat (2) @(posedge clk);
      #1;
      chk({11'h0, host_valid, host_conflict, host_port}, 16'h0016);
      tail_tag_en = 7'h41;
      repeat (2) @(posedge clk);
      #1;
      chk({12'h0, host_conflict, host_port}, 16'h0008);
      $display("test reset and host done");
      for (int md = 0; md < 4; md++) begin
         for (int n = 0; n < 6; n++) begin
            hash_mode = md[1:0];
            vlan_en = n[0];
            mac = {16'($random(seed)), 32'($random(seed))};
            mac[40] = 1'b0;
            fgrp = 7'($random(seed));
            if (n == 5) begin
               mac[9:0] = 10'h3FF;
               fgrp = 7'h7F;
            end
            ef = vlan_en ? fgrp : 7'h00;
            mg(1'b0, {bidx(mac, ef, hash_mode), n[1:0]}, mac, ef, 7'(n + 1));
            lk(mac, SA_MC, fgrp, 3'h1, 1'b1, {1'b1, 7'(n + 1)});
         end
      end
      $display("test hash modes done");
      hash_mode = 2'b01;
      vlan_en = 1'b0;
      lk(48'h0200_0000_0001, 48'h0011_2233_4455, 7'h00, 3'h3, 1'b1, 8'h00);
      lk(48'h0011_2233_4455, SA_MC, 7'h00, 3'h0, 1'b1, 8'h88);
      lk(48'h0200_0000_0001, 48'h0022_0000_0001, 7'h00, 3'h2, 1'b0, 8'h00);
      lk(48'h0022_0000_0001, SA_MC, 7'h00, 3'h0, 1'b1, 8'h00);
      lk(48'h0200_0000_0001, 48'h0300_0000_0077, 7'h00, 3'h2, 1'b1, 8'h00);
      lk(48'h0300_0000_0077, SA_MC, 7'h00, 3'h0, 1'b1, 8'h00);
      $display("test learning done");
      mac = 48'h0000_ABCD_EF01;
      mg(1'b0, {bidx(mac, 7'h00, 2'b01), 2'h2}, mac, 7'h00, 7'h02);
      mg(1'b1, 12'h005, mac, 7'h00, 7'h10);
      lk(mac, SA_MC, 7'h00, 3'h0, 1'b1, 8'h90);
      @(posedge clk);
      #1;
      {mgmt_wr, mgmt_sel, mgmt_valid} = 3'b110;
      mgmt_idx = 12'h005;
      @(posedge clk);
      #1;
      {mgmt_wr, mgmt_valid} = 2'b01;
      lk(mac, SA_MC, 7'h00, 3'h0, 1'b1, 8'h82);
      $display("test priority done");
      hash_mode = 2'b00;
      for (int w = 0; w < 4; w++)
         mg(1'b0, {10'h155, 2'(w)}, {16'h0, 16'(w + 1), 16'h0155}, 7'h00, 7'h01);
      lk(48'h0200_0000_0009, 48'h0000_0009_0155, 7'h00, 3'h4, 1'b1, 8'h00);
      lk(48'h0000_0009_0155, SA_MC, 7'h00, 3'h0, 1'b1, 8'h00);
      chk(16'(full_seen), 16'h0001);
      chk({6'h0, full_bkt}, 16'h0155);
      lk(48'h0000_0001_0155, SA_MC, 7'h00, 3'h0, 1'b1, 8'h81);
      $display("test full bucket done");
      rsv_en = 1'b1;
      lk(48'h0180_C200_0010, SA_MC, 7'h00, 3'h0, 1'b1, 8'hFF);
      lk(48'h0180_C200_0000, SA_MC, 7'h00, 3'h0, 1'b1, 8'hC0);
      @(posedge clk);
      #1;
      rsv_wr = 1'b1;
      rsv_ports = 7'h15;
      @(posedge clk);
      #1;
      rsv_wr = 1'b0;
      lk(48'h0180_C200_0000, SA_MC, 7'h00, 3'h0, 1'b1, 8'h95);
      rsv_en = 1'b0;
      lk(48'h0180_C200_0010, SA_MC, 7'h00, 3'h0, 1'b1, 8'h00);
      $display("test reserved done");
      repeat (5) @(posedge clk);
      chk(16'(exp_q.size()), 16'h0000);
      end_of_test();
   end
endmodule // salh_lookup_tb_top

// ==== tb/salh_rx_mac_model.sv ====
`timescale 1ns/10ps
module salh_rx_mac_model (
   input wire logic clk, // core clock
   input wire logic req_ready, // lookup engine idle
   output logic req_valid, // lookup request
   output logic [47:0] req_da, // destination address
   output logic [47:0] req_sa, // source address
   output logic [6:0] req_fgrp, // frame filter group
   output logic [2:0] req_port, // ingress port
   output logic req_frame_ok // frame good and legal length
);
   // ****************************************
   // receive path: one finished frame per request
   // ****************************************
   initial begin
      req_valid = 1'b0;
      req_da = 48'h0;
      req_sa = 48'h0;
      req_fgrp = 7'h00;
      req_port = 3'h0;
      req_frame_ok = 1'b0;
   end

   // only a whole frame is offered, so the lookup never sees a partial one
   task automatic send(input logic [47:0] da, sa, input logic [6:0] fgrp,
                       input logic [2:0] port, input logic ok);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      req_valid = 1'b1;
      req_da = da;
      req_sa = sa;
      req_fgrp = fgrp;
      req_port = port;
      req_frame_ok = ok;
      while (!req_ready && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      // released fields go inverse so stale values never pass for a request
      req_da = ~da;
      req_sa = ~sa;
      req_fgrp = ~fgrp;
      req_port = ~port;
      req_frame_ok = ~ok;
   endtask
endmodule // salh_rx_mac_model
